// ---- shared/gtb_pkg.sv ----
`default_nettype none
package gtb_pkg;
  // ==========================================================
  // Counting methods and trigger sources
  // ==========================================================
  typedef enum logic [1:0] {
    GTB_M_UP16   = 2'b00,
    GTB_M_UPDN16 = 2'b01,
    GTB_M_SPLIT8 = 2'b10,
    GTB_M_CASC8  = 2'b11
  } gtb_method_t;

  typedef enum logic [1:0] {
    GTB_T_ALWAYS = 2'b00,
    GTB_T_CMP    = 2'b01,
    GTB_T_OPAMP  = 2'b10,
    GTB_T_CAPT   = 2'b11
  } gtb_trig_t;

  // ==========================================================
  // Divider terminal counts, ratio minus one per field code
  // ==========================================================
  localparam int          GTB_DIV_W     = 4;
  localparam logic [3:0]  GTB_DIV_LAST0 = 4'h1;
  localparam logic [3:0]  GTB_DIV_LAST1 = 4'h3;
  localparam logic [3:0]  GTB_DIV_LAST2 = 4'h7;
  localparam logic [3:0]  GTB_DIV_LAST3 = 4'hF;

  // ==========================================================
  // Field positions of the clock control word and reset values
  // ==========================================================
  localparam int          GTB_CKEN_BIT  = 6;
  localparam int          GTB_CKDIV_HI  = 5;
  localparam int          GTB_CKDIV_LO  = 4;
  localparam int          GTB_MODE_HI   = 3;
  localparam int          GTB_MODE_LO   = 2;
  localparam logic [15:0] GTB_CNT_RST   = 16'h0000;
  localparam logic [7:0]  GTB_BYTE_MAX  = 8'hFF;
  localparam logic [3:0]  GTB_DIV_RST   = 4'h0;
endpackage : gtb_pkg
`default_nettype wire

// ---- core/gtb_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module gtb_timer
  import gtb_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // Clock control word bits
  input  wire logic [6:4]  clock_ctrl_i,
  // Timer control
  input  wire logic        timer_run_enable_i,
  input  wire logic        count_clear_wr_i,
  input  wire logic [1:0]  trigger_source_select_i,
  input  wire logic [3:2]  counting_method_select_i,
  input  wire logic [15:0] overflow_compare_value_i,
  input  wire logic [15:0] second_compare_value_i,
  input  wire logic [15:0] third_compare_value_i,
  // Interrupt control
  input  wire logic        timer_irq_enable_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic        flag_clear_i,
  // Trigger sources from outside this clock domain
  input  wire logic        comparator_output_i,
  input  wire logic        opamp_digital_output_i,
  input  wire logic        capture_timer_output_i,
  // Status
  output logic [15:0]      timer_count_value_o,
  output logic             count_clear_bit_o,
  output logic             timer_overflow_flag_o,
  output logic             timer_irq_o,
  output logic             divided_count_clock_o,
  output logic             count_down_o,
  output logic             second_match_o,
  output logic             third_match_o
);

  // ==========================================================
  // Trigger synchronisers
  // ==========================================================
  logic [2:0] trig_meta;
  logic [2:0] trig_sync;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_meta <= 3'h0;
      trig_sync <= 3'h0;
    end else if (ce_i) begin
      trig_meta <= {capture_timer_output_i, opamp_digital_output_i,
                    comparator_output_i};
      trig_sync <= trig_meta;
    end
  end

  // ==========================================================
  // Count clock divider
  // ==========================================================
  function automatic logic [3:0] div_last(input logic [1:0] sel);
    case (sel)
      2'b00:   div_last = GTB_DIV_LAST0;
      2'b01:   div_last = GTB_DIV_LAST1;
      2'b10:   div_last = GTB_DIV_LAST2;
      default: div_last = GTB_DIV_LAST3;
    endcase
  endfunction : div_last

  logic                 clk_en;
  logic [1:0]           div_sel;
  logic [GTB_DIV_W-1:0] div_cnt;
  logic [GTB_DIV_W-1:0] next_div_cnt;
  logic                 div_tick;
  logic                 next_div_clk;

  assign clk_en  = clock_ctrl_i[GTB_CKEN_BIT];
  assign div_sel = clock_ctrl_i[GTB_CKDIV_HI:GTB_CKDIV_LO];

  always_comb begin
    div_tick     = 1'b0;
    next_div_cnt = div_cnt;
    next_div_clk = divided_count_clock_o;
    if (!clk_en) begin
      next_div_cnt = GTB_DIV_RST;
      next_div_clk = 1'b0;
    end else if (div_cnt >= div_last(div_sel)) begin
      div_tick     = 1'b1;
      next_div_cnt = GTB_DIV_RST;
      next_div_clk = 1'b1;
    end else begin
      next_div_cnt = div_cnt + 4'h1;
      if (div_cnt == (div_last(div_sel) >> 1))
        next_div_clk = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt               <= GTB_DIV_RST;
      divided_count_clock_o <= 1'b0;
    end else if (ce_i) begin
      div_cnt               <= next_div_cnt;
      divided_count_clock_o <= next_div_clk;
    end
  end

  // ==========================================================
  // Trigger gate
  // ==========================================================
  logic gate;
  logic step;

  always_comb begin
    case (gtb_trig_t'(trigger_source_select_i))
      GTB_T_ALWAYS: gate = 1'b1;
      GTB_T_CMP:    gate = trig_sync[0];
      GTB_T_OPAMP:  gate = trig_sync[1];
      GTB_T_CAPT:   gate = trig_sync[2];
      default:      gate = 1'b0;
    endcase
  end

  // Ticks only advance the counter while the timer runs.
  assign step = div_tick && gate && timer_run_enable_i;

  // ==========================================================
  // Counter, direction, clear and flag
  // ==========================================================
  gtb_method_t method;
  logic [7:0]  cmp_lo;
  logic [7:0]  cmp_hi;
  logic [7:0]  cnt_lo;
  logic [7:0]  cnt_hi;
  logic [15:0] next_count;
  logic        next_down;
  logic        next_clear;
  logic        next_flag;
  logic        next_irq;
  logic        ovf_event;

  assign method = gtb_method_t'(counting_method_select_i);
  assign cmp_lo = overflow_compare_value_i[7:0];
  assign cmp_hi = overflow_compare_value_i[15:8];
  assign cnt_lo = timer_count_value_o[7:0];
  assign cnt_hi = timer_count_value_o[15:8];

  always_comb begin
    next_count = timer_count_value_o;
    next_down  = count_down_o;
    ovf_event  = 1'b0;
    if (method != GTB_M_UPDN16)
      next_down = 1'b0;
    if (step) begin
      case (method)
        GTB_M_UP16: begin
          // A compare value lowered below the count still wraps.
          if (timer_count_value_o >= overflow_compare_value_i) begin
            next_count = GTB_CNT_RST;
            ovf_event  = 1'b1;
          end else begin
            next_count = timer_count_value_o + 16'h0001;
          end
        end
        GTB_M_UPDN16: begin
          if (count_down_o) begin
            if (timer_count_value_o <= 16'h0001) begin
              next_count = GTB_CNT_RST;
              next_down  = 1'b0;
              ovf_event  = 1'b1;
            end else begin
              next_count = timer_count_value_o - 16'h0001;
            end
          end else if (timer_count_value_o >= overflow_compare_value_i) begin
            if (timer_count_value_o == GTB_CNT_RST) begin
              ovf_event = 1'b1;
            end else begin
              next_count = timer_count_value_o - 16'h0001;
              next_down  = 1'b1;
            end
          end else begin
            next_count = timer_count_value_o + 16'h0001;
          end
        end
        GTB_M_SPLIT8: begin
          if (cnt_hi >= cmp_hi)
            next_count[15:8] = 8'h00;
          else
            next_count[15:8] = cnt_hi + 8'h01;
          if (cnt_lo >= cmp_lo) begin
            next_count[7:0] = 8'h00;
            ovf_event       = 1'b1;
          end else begin
            next_count[7:0] = cnt_lo + 8'h01;
          end
        end
        GTB_M_CASC8: begin
          if (cnt_lo >= cmp_lo) begin
            next_count[7:0]  = 8'h00;
            next_count[15:8] = cnt_hi + 8'h01;
            ovf_event        = 1'b1;
          end else begin
            next_count[7:0] = cnt_lo + 8'h01;
          end
        end
        default: next_count = timer_count_value_o;
      endcase
    end
    // The clear bit is held one cycle, so the zeroing wins over counting.
    next_clear = count_clear_wr_i;
    if (count_clear_bit_o) begin
      next_count = GTB_CNT_RST;
      next_down  = 1'b0;
      next_clear = count_clear_wr_i && !count_clear_bit_o;
    end
    // An overflow in the clearing cycle is kept: set beats clear.
    next_flag = ovf_event || (timer_overflow_flag_o && !flag_clear_i);
    next_irq  = next_flag && timer_irq_enable_i && global_irq_enable_i;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_count_value_o   <= GTB_CNT_RST;
      count_down_o          <= 1'b0;
      count_clear_bit_o     <= 1'b0;
      timer_overflow_flag_o <= 1'b0;
      timer_irq_o           <= 1'b0;
    end else if (ce_i) begin
      timer_count_value_o   <= next_count;
      count_down_o          <= next_down;
      count_clear_bit_o     <= next_clear;
      timer_overflow_flag_o <= next_flag;
      timer_irq_o           <= next_irq;
    end
  end

  // ==========================================================
  // Further compare values
  // ==========================================================
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      second_match_o <= 1'b0;
      third_match_o  <= 1'b0;
    end else if (ce_i) begin
      second_match_o <= (next_count == second_compare_value_i);
      third_match_o  <= (next_count == third_compare_value_i);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  hold_when_stopped_a: assert property (
    ce_i && !timer_run_enable_i && !count_clear_bit_o |=> $stable(timer_count_value_o))
    else $error("Counter moved while run enable was low.");

  tick_only_a: assert property (
    ce_i && !div_tick && !count_clear_bit_o |=> $stable(timer_count_value_o))
    else $error("Counter moved without a divided tick.");

  clear_self_a: assert property (
    ce_i && count_clear_bit_o && !count_clear_wr_i
    |=> timer_count_value_o == 16'h0000 && !count_clear_bit_o)
    else $error("Clear did not zero the counter and drop.");

  wrap_up16_a: assert property (
    step && ce_i && method == GTB_M_UP16 && !count_clear_bit_o
    && timer_count_value_o == overflow_compare_value_i
    |=> timer_count_value_o == 16'h0000 && timer_overflow_flag_o)
    else $error("Method 00 did not wrap with flag.");

  turn_down_a: assert property (
    step && ce_i && method == GTB_M_UPDN16 && !count_down_o && !count_clear_bit_o
    && timer_count_value_o == overflow_compare_value_i
    && timer_count_value_o != 16'h0000 && !timer_overflow_flag_o && !ovf_event
    |=> count_down_o && !timer_overflow_flag_o)
    else $error("Method 01 did not turn down cleanly.");

  bottom_up_a: assert property (
    step && ce_i && method == GTB_M_UPDN16 && count_down_o && !count_clear_bit_o
    && timer_count_value_o == 16'h0001
    |=> timer_count_value_o == 16'h0000 && !count_down_o && timer_overflow_flag_o)
    else $error("Method 01 did not flag at zero.");

  split_hi_a: assert property (
    step && ce_i && method == GTB_M_SPLIT8 && !count_clear_bit_o
    && cnt_hi == cmp_hi && cnt_lo < cmp_lo && !timer_overflow_flag_o
    |=> timer_count_value_o[15:8] == 8'h00 && !timer_overflow_flag_o)
    else $error("High byte wrap raised the flag.");

  cascade_a: assert property (
    step && ce_i && method == GTB_M_CASC8 && !count_clear_bit_o && cnt_lo == cmp_lo
    |=> timer_count_value_o[7:0] == 8'h00
        && timer_count_value_o[15:8] == $past(cnt_hi) + 8'h01 && timer_overflow_flag_o)
    else $error("Cascade did not carry into high byte.");

  irq_gate_a: assert property (
    ce_i |=> timer_irq_o == (timer_overflow_flag_o && $past(timer_irq_enable_i)
                             && $past(global_irq_enable_i)))
    else $error("Request without flag and enables.");

  flag_clear_a: assert property (
    ce_i && flag_clear_i && !ovf_event |=> !timer_overflow_flag_o && !timer_irq_o)
    else $error("Flag clear did not withdraw request.");

  cover_wrap_c:  cover property (ovf_event && step && method == GTB_M_UP16);
  cover_down_c:  cover property (!count_down_o ##1 count_down_o);
  cover_casc_c:  cover property (ovf_event && step && method == GTB_M_CASC8);
  cover_irq_c:   cover property (timer_irq_o ##1 !timer_irq_o);

endmodule : gtb_timer
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, nrst, ce, run, clr_wr, ie, gie, fclr, cmp_s, op_s, cap_s;
  logic [6:4]  cc;
  logic [1:0]  trig;
  logic [3:2]  mth;
  logic [15:0] c0, c2, c3, cnt, v, pc;
  logic        clrb, flg, irq, dcc, dn, m2, m3;
  logic        pf, pk, pr, ice, irun, iw, iie, igie, ifc, rose, step;
  logic        stab = 1'b0;
  logic [1:0]  itr;
  logic [6:4]  idv, ldv;
  logic [18:0] e;
  logic [31:0] r;
  logic [15:0] crn [4];
  int          seed, gap;
  int          error_cnt = 0;
  int          n_tests = 0;

  gtb_timer i_dut (
    .sys_clk_i               (clk),
    .nrst_i                  (nrst),
    .ce_i                    (ce),
    .clock_ctrl_i            (cc),
    .timer_run_enable_i      (run),
    .count_clear_wr_i        (clr_wr),
    .trigger_source_select_i (trig),
    .counting_method_select_i(mth),
    .overflow_compare_value_i(c0),
    .second_compare_value_i  (c2),
    .third_compare_value_i   (c3),
    .timer_irq_enable_i      (ie),
    .global_irq_enable_i     (gie),
    .flag_clear_i            (fclr),
    .comparator_output_i     (cmp_s),
    .opamp_digital_output_i  (op_s),
    .capture_timer_output_i  (cap_s),
    .timer_count_value_o     (cnt),
    .count_clear_bit_o       (clrb),
    .timer_overflow_flag_o   (flg),
    .timer_irq_o             (irq),
    .divided_count_clock_o   (dcc),
    .count_down_o            (dn),
    .second_match_o          (m2),
    .third_match_o           (m3)
  );

  // ==========================================================
  // Expected next state: {unsure, flag, down, count}
  // ==========================================================
  function automatic logic [18:0] nxt(input logic [1:0] m, input logic [15:0] c, k,
                                      input logic d);
    nxt = {3'b000, c + 16'h0001};
    if (m == 2'h0 && c >= k) nxt = {3'b010, 16'h0000};
    if (m == 2'h1) begin
      // A turn down from a count of 1 leaves a state whose next step is not pinned down.
      if (k == 16'h0000) nxt = {3'b010, 16'h0000};
      else if (d && c == 16'h0000) nxt[18] = 1'b1;
      else if (d && c == 16'h0001) nxt = {3'b010, 16'h0000};
      else if (d) nxt = {3'b001, c - 16'h0001};
      else if (c >= k) nxt = {3'b001, k - 16'h0001};
    end
    if (m == 2'h2) nxt = {1'b0, c[7:0] >= k[7:0], 1'b0,
                          c[15:8] >= k[15:8] ? 8'h00 : c[15:8] + 8'h01,
                          c[7:0] >= k[7:0] ? 8'h00 : c[7:0] + 8'h01};
    if (m == 2'h3 && c[7:0] >= k[7:0]) nxt = {3'b010, c[15:8] + 8'h01, 8'h00};
  endfunction : nxt

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task end_sim;
    $display("Comparisons: %0d, mismatches: %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic run_rand(input int n);
    repeat (n) begin
      @(negedge clk);
      r = $random(seed);
      {ie, gie} = r[1:0];
      fclr = r[4:2] == 3'h0;
      ce = r[8:5] != 4'h0;
      clr_wr = r[14:9] == 6'h00 && !clr_wr && !clrb;
      run = r[20:15] != 6'h00;
    end
    // Let the last random values meet one edge before the caller drives again.
    @(negedge clk);
  endtask : run_rand

  // ==========================================================
  // Clock, watchdog and cycle monitor
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim;
  end

  // Inputs are captured before the edge lands, outputs looked at 1 ns after it.
  always begin
    @(posedge clk);
    {pc, pf, pk, pr} = {cnt, flg, clrb, dcc};
    e = nxt(mth, cnt, c0, dn);
    {ice, irun, iw, iie, igie, ifc, itr, idv} = {ce, run, clr_wr, ie, gie, fclr, trig, cc};
    #1;
    if (!nrst) stab = 1'b0;
    else if (!ice) chk(cnt === pc && flg === pf && clrb === pk, "freeze");
    else begin
      rose = dcc && !pr;
      step = rose && irun;
      if (iw) chk(clrb === 1'b1, "clear bit set");
      else if (pk) chk(cnt === 16'h0000 && clrb === 1'b0, "clear done");
      else if (!step) chk(cnt === pc && flg === (pf && !ifc), "idle hold");
      else if (itr != 2'h0) chk(cnt === pc || cnt === e[15:0], "gated step");
      else if (!e[18]) begin
        chk(cnt === e[15:0], "count step");
        chk(flg === (e[17] || (pf && !ifc)), "flag update");
        if (mth == 2'h1) chk(dn === e[16], "direction");
      end
      chk(irq === (flg && iie && igie), "irq gating");
      if (idv !== ldv) stab = 1'b0;
      if (rose && stab) chk(gap + 1 == (2 << idv[5:4]), "divider ratio");
      if (rose) stab = 1'b1;
      gap = rose ? 0 : gap + 1;
      ldv = idv;
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = 32'h0000_01AD;
    {nrst, ce, run, clr_wr, ie, gie, fclr, cmp_s, op_s, cap_s} = 10'h100;
    {cc, trig, mth, c0, c2, c3} = 55'h0;
    crn = '{16'h0000, 16'h0002, 16'h0300, 16'h0000};
    cyc(6);
    chk({cnt, clrb, flg, irq, dcc, dn, m2, m3} === 23'h0, "reset values");
    nrst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      ce = 1'b1;
      run = 1'b0;
      cc = {1'b1, i[1:0] + i[2]};
      mth = i[1:0];
      trig = 2'h0;
      c0 = i < 4 ? {6'h00, i[1] ? r[9:8] : 2'h0, 8'h02 + {4'h0, r[3:0]}}
                   + {7'h00, i[1], 8'h00} : crn[i[1:0]];
      clr_wr = 1'b1;
      cyc(1);
      clr_wr = 1'b0;
      run = 1'b1;
      run_rand(i < 4 ? 500 : 800);
    end
    // Only the selected source may open the gate; the others are held the wrong way.
    {ce, run, clr_wr, fclr, cc, mth, c0} = {4'hC, 3'h4, 2'h0, 16'h0FFF};
    for (int t = 1; t < 4; t++) begin
      trig = t[1:0];
      {cap_s, op_s, cmp_s} = ~(3'h1 << (t[1:0] - 2'h1));
      cyc(20);
      v = cnt;
      cyc(40);
      chk(cnt === v, "gate closed");
      {cap_s, op_s, cmp_s} = 3'h1 << (t[1:0] - 2'h1);
      cyc(20);
      v = cnt;
      cyc(40);
      chk(cnt !== v, "gate open");
    end
    cc = 3'h0;
    cyc(3);
    v = cnt;
    cyc(40);
    chk(cnt === v && dcc === 1'b0, "count clock off");
    run = 1'b0;
    c2 = cnt;
    c3 = cnt + 16'h0001;
    cyc(3);
    chk(m2 === 1'b1 && m3 === 1'b0, "compare match");
    nrst = 1'b0;
    cyc(2);
    chk({cnt, clrb, flg, irq, dcc, dn} === 21'h0, "second reset");
    nrst = 1'b1;
    cyc(5);
    end_sim;
  end
endmodule : tb
`default_nettype wire
